/* File: flash_cmd_asserts.sv */
// Purpose: port assertions of the flash command error checker
// Assumes: one clock domain, asynchronous active-high reset
// Notes: bound to the design at the foot of this file
`timescale 1ns/1ns
`default_nettype none

module flash_cmd_asserts #(
  parameter logic [7:0] CMD_VERIFY = 8'h01,
  parameter logic [7:0] CMD_PROGRAM = 8'h02,
  parameter logic [7:0] CMD_ERASE = 8'h03,
  parameter logic [7:0] CMD_MASS_ERASE = 8'h04,
  parameter logic [15:0] INVALID_DATA = 16'hffff
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [15:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic exec_busy,
  input wire logic engine_ready,
  input wire logic cmd_valid,
  input wire flash_cmd_check_pkg::cmd_t cmd_out,
  input wire logic cmd_abort,
  input wire logic access_error_flag,
  input wire logic protection_violation_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire logic wr_go = write && !waitrequest;
  wire logic arr = address >= 16'h4000;
  wire logic st_wr = wr_go && address == 16'h0108 && byteenable[0];
  wire logic bad_code = !(writedata[7:0] inside {CMD_VERIFY, CMD_PROGRAM, CMD_ERASE,
    CMD_MASS_ERASE});
  property p_one_wait;
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait cycle count wrong");
  property p_misalign;
    wr_go && arr && byteenable != 4'h3 && byteenable != 4'hc |=> access_error_flag;
  endproperty
  a_misalign: assert property (p_misalign) else $error("byte write not flagged");
  property p_bad_code;
    wr_go && address == 16'h010c && byteenable[0] && bad_code |=> access_error_flag;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code not flagged");
  property p_read_quiet;
    read && !waitrequest |=> $stable(access_error_flag) && $stable(protection_violation_flag);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read changed a flag");
  property p_busy_read;
    read && waitrequest && exec_busy && arr |=> readdata == {INVALID_DATA, INVALID_DATA};
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy read not invalid");
  property p_ae_lock;
    $rose(cmd_valid) |-> !$past(access_error_flag);
  endproperty
  a_ae_lock: assert property (p_ae_lock) else $error("launch while error set");
  property p_pv_lock;
    $rose(cmd_valid) |-> !$past(protection_violation_flag);
  endproperty
  a_pv_lock: assert property (p_pv_lock) else $error("launch while violation set");
  property p_stop;
    cmd_abort |-> ##[0:1] access_error_flag;
  endproperty
  a_stop: assert property (p_stop) else $error("abort without error flag");
  property p_abort_pulse;
    cmd_abort |=> !cmd_abort;
  endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort pulse too long");
  property p_zero_keep;
    st_wr && !writedata[4] && access_error_flag |=> access_error_flag;
  endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("zero write cleared flag");
  property p_hold;
    cmd_valid && !engine_ready && !exec_busy |=> cmd_valid && $stable(cmd_out);
  endproperty
  a_hold: assert property (p_hold) else $error("pending command not held");
  c_launch: cover property ($rose(cmd_valid));
  c_abort: cover property (cmd_abort);
  c_viol: cover property ($rose(protection_violation_flag));
endmodule : flash_cmd_asserts

bind flash_command_error_checker flash_cmd_asserts #(.CMD_VERIFY(CMD_VERIFY),
  .CMD_PROGRAM(CMD_PROGRAM), .CMD_ERASE(CMD_ERASE), .CMD_MASS_ERASE(CMD_MASS_ERASE),
  .INVALID_DATA(INVALID_DATA)) flash_cmd_asserts_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .exec_busy(exec_busy), .engine_ready(engine_ready), .cmd_valid(cmd_valid),
  .cmd_out(cmd_out), .cmd_abort(cmd_abort), .access_error_flag(access_error_flag),
  .protection_violation_flag(protection_violation_flag));

`default_nettype wire

/* File: flash_cmd_check_defines.svh */
// Purpose: constants of the flash command error checker
// Assumes: 16-bit byte address space seen over a 32-bit Avalon-MM slave
// Notes: offsets are byte addresses
//
// Function
// - array write before clock divider set errors
// - byte or misaligned array word write errors
// - array write with buffer not empty errors
// - second array word before command errors
// - after word, non-command register write errors
// - second command before launch errors
// - unsupported command code errors
// - after command, non-status register write errors
// - stop mode while busy aborts running command, kills pending
// - secured: only mass erase from untrusted source
// - writing zero to buffer flag aborts
// - register reads never error or abort
// - array read while busy: invalid data
// - access error locks command launch
// - program into protected area: violation
// - erase in protected area: violation
// - mass erase with protection on: violation
// - protection violation locks command launch
// - low range at 0x4000, size 1-8 Kbytes
// - protection loaded after reset, software-changeable
`ifndef FLASH_CMD_CHECK_DEFINES_SVH
`define FLASH_CMD_CHECK_DEFINES_SVH

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define FCC_REG_PAGE 12'h010
`define FCC_OFS_CLKDIV 4'h0
`define FCC_OFS_PROT 4'h4
`define FCC_OFS_STATUS 4'h8
`define FCC_OFS_CMD 4'hc
`define FCC_ARRAY_LO 16'h4000
`define FCC_LOW_BASE 17'h04000
`define FCC_LOW_1K 17'h00400
`define FCC_HIGH_TOP 17'h10000
`define FCC_HIGH_2K 17'h00800

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define FCC_BIT_CBE 7
`define FCC_BIT_CC 6
`define FCC_BIT_PV 5
`define FCC_BIT_AE 4

// ----------------------------------------------------------------
// protection register bits
// ----------------------------------------------------------------
`define FCC_BIT_OPEN 7
`define FCC_BIT_HDIS 5
`define FCC_BIT_HS 3
`define FCC_BIT_LDIS 2
`define FCC_BIT_LS 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FCC_RST_PROT 8'hff
`define FCC_RST_CLKDIV 8'h00

`endif

/* File: flash_cmd_check_pkg.sv */
// Purpose: types of the flash command error checker
// Assumes: nothing
// Notes: none
package flash_cmd_check_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WORD,
    SEQ_CMD
  } seq_state_t;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] addr;
    logic [15:0] data;
  } cmd_t;

  typedef struct packed {
    logic open_all;
    logic high_dis;
    logic [1:0] high_size;
    logic low_dis;
    logic [1:0] low_protect_size_field;
  } prot_t;

endpackage : flash_cmd_check_pkg

/* File: flash_command_error_checker.sv */
// Purpose: watches the flash command write sequence and flags illegal steps
// Assumes: Avalon-MM slave, array read data supplied by memory on the same bus
// Notes: launched commands are handed to the flash engine by valid/ready
`include "flash_cmd_check_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module flash_command_error_checker #(
  parameter logic [7:0] CMD_VERIFY = 8'h01,
  parameter logic [7:0] CMD_PROGRAM = 8'h02,
  parameter logic [7:0] CMD_ERASE = 8'h03,
  parameter logic [7:0] CMD_MASS_ERASE = 8'h04,
  parameter logic [15:0] INVALID_DATA = 16'hffff
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [15:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // access source qualifiers, same clock as the bus
  input wire logic src_nonsecure,
  input wire logic src_debug,
  input wire logic secure_en,
  input wire logic normal_mode,
  // array data for the addressed word
  input wire logic [15:0] array_rdata,
  // protection image from the array after reset
  input wire logic prot_load,
  input wire flash_cmd_check_pkg::prot_t prot_load_value,
  // stop mode request pin
  input wire logic stop_req,
  // flash engine side
  input wire logic exec_busy,
  input wire logic engine_ready,
  output logic cmd_valid,
  output flash_cmd_check_pkg::cmd_t cmd_out,
  output logic cmd_abort,
  output logic [7:0] clkdiv,
  output logic access_error_flag,
  output logic protection_violation_flag
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  flash_cmd_check_pkg::seq_state_t state_r;
  flash_cmd_check_pkg::seq_state_t state_nxt;
  flash_cmd_check_pkg::cmd_t buf_r;
  flash_cmd_check_pkg::cmd_t cmd_r;
  flash_cmd_check_pkg::prot_t prot_r;
  flash_cmd_check_pkg::prot_t prot_nxt;
  logic wait_r;
  logic [31:0] rdata_r;
  logic cmd_valid_r;
  logic abort_r;
  logic [7:0] clkdiv_r;
  logic div_done_r;
  logic access_error_flag_r;
  logic protection_violation_flag_r;
  logic stop_s1_r;
  logic stop_s2_r;
  logic stop_s3_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req = read | write;
  wire acc = req & ~wait_r;
  wire wr_acc = write & acc;
  wire hit_arr = address >= `FCC_ARRAY_LO;
  wire hit_reg = address[15:4] == `FCC_REG_PAGE;
  wire sel_div = hit_reg & (address[3:0] == `FCC_OFS_CLKDIV);
  wire sel_prot = hit_reg & (address[3:0] == `FCC_OFS_PROT);
  wire sel_stat = hit_reg & (address[3:0] == `FCC_OFS_STATUS);
  wire sel_cmd = hit_reg & (address[3:0] == `FCC_OFS_CMD);
  wire arr_wr = wr_acc & hit_arr;
  wire reg_wr = wr_acc & hit_reg;
  wire word_ok = (byteenable == 4'b0011) | (byteenable == 4'b1100);
  wire [15:0] lane_data = byteenable[2] ? writedata[31:16] : writedata[15:0];
  wire [15:0] arr_addr = {address[15:2], byteenable[2], 1'b0};
  wire [7:0] wr_code = writedata[7:0];
  wire wr_cbe = writedata[`FCC_BIT_CBE];
  wire command_buffer_empty_flag = ~cmd_valid_r;
  wire command_complete_flag = ~exec_busy & ~cmd_valid_r;
  wire locked = access_error_flag_r | protection_violation_flag_r;

  // ----------------------------------------------------------------
  // protection ranges
  // ----------------------------------------------------------------
  wire [16:0] low_size = `FCC_LOW_1K << prot_r.low_protect_size_field;
  wire [16:0] high_size = `FCC_HIGH_2K << prot_r.high_size;
  wire [16:0] buf_addr17 = {1'b0, buf_r.addr};
  wire in_low = (buf_addr17 >= `FCC_LOW_BASE) & (buf_addr17 < `FCC_LOW_BASE + low_size);
  wire in_high = buf_addr17 >= (`FCC_HIGH_TOP - high_size);
  wire in_range = (~prot_r.low_dis & in_low) | (~prot_r.high_dis & in_high);
  wire addr_prot = prot_r.open_all ? in_range : ~in_range;
  wire any_prot = ~prot_r.open_all | ~prot_r.low_dis | ~prot_r.high_dis;

  // ----------------------------------------------------------------
  // command checks
  // ----------------------------------------------------------------
  wire code_valid = (wr_code == CMD_VERIFY) | (wr_code == CMD_PROGRAM) |
                    (wr_code == CMD_ERASE) | (wr_code == CMD_MASS_ERASE);
  wire untrusted = secure_en & (src_nonsecure | src_debug);
  wire is_mass = wr_code == CMD_MASS_ERASE;
  wire is_prog = wr_code == CMD_PROGRAM;
  wire is_erase = wr_code == CMD_ERASE;

  // ----------------------------------------------------------------
  // access error sources
  // ----------------------------------------------------------------
  wire ae_no_div = arr_wr & ~div_done_r;
  wire ae_align = arr_wr & ~word_ok;
  wire ae_buf_full = arr_wr & ~command_buffer_empty_flag;
  wire ae_second_word = arr_wr & (state_r != flash_cmd_check_pkg::SEQ_IDLE);
  wire ae_after_word = reg_wr & ~sel_cmd & (state_r == flash_cmd_check_pkg::SEQ_WORD);
  wire cmd_wr = reg_wr & sel_cmd;
  wire ae_second_cmd = cmd_wr & (state_r == flash_cmd_check_pkg::SEQ_CMD);
  wire ae_no_word = cmd_wr & (state_r == flash_cmd_check_pkg::SEQ_IDLE);
  wire cmd_in_word = cmd_wr & (state_r == flash_cmd_check_pkg::SEQ_WORD);
  wire ae_bad_code = cmd_in_word & ~code_valid;
  wire ae_secure = cmd_in_word & code_valid & untrusted & ~is_mass;
  wire ae_after_cmd = reg_wr & ~sel_stat & (state_r == flash_cmd_check_pkg::SEQ_CMD);
  wire stat_wr = reg_wr & sel_stat;
  wire ae_user_abort = stat_wr & ~wr_cbe & (state_r != flash_cmd_check_pkg::SEQ_IDLE);
  wire stop_rise = stop_s2_r & ~stop_s3_r;
  wire ae_stop = stop_rise & exec_busy;

  wire ae_set = ae_no_div | ae_align | ae_buf_full | ae_second_word | ae_after_word |
                ae_second_cmd | ae_no_word | ae_bad_code | ae_secure | ae_after_cmd |
                ae_user_abort | ae_stop;

  // ----------------------------------------------------------------
  // protection violation sources
  // ----------------------------------------------------------------
  wire cmd_clean = cmd_in_word & code_valid & ~(untrusted & ~is_mass);
  wire pv_prog = cmd_clean & is_prog & addr_prot;
  wire pv_erase = cmd_clean & is_erase & addr_prot;
  wire pv_mass = cmd_clean & is_mass & any_prot;
  wire pv_set = pv_prog | pv_erase | pv_mass;

  // ----------------------------------------------------------------
  // sequence progress
  // ----------------------------------------------------------------
  wire word_good = arr_wr & ~ae_set;
  wire cmd_good = cmd_in_word & ~ae_set & ~pv_set;
  wire launch = stat_wr & wr_cbe & (state_r == flash_cmd_check_pkg::SEQ_CMD) &
                ~locked & command_buffer_empty_flag;
  wire handoff = cmd_valid_r & engine_ready;

  always_comb begin
    state_nxt = state_r;
    if (ae_set | pv_set) begin
      state_nxt = flash_cmd_check_pkg::SEQ_IDLE;
    end else if (word_good) begin
      state_nxt = flash_cmd_check_pkg::SEQ_WORD;
    end else if (cmd_good) begin
      state_nxt = flash_cmd_check_pkg::SEQ_CMD;
    end else if (launch) begin
      state_nxt = flash_cmd_check_pkg::SEQ_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // flag update, set wins over clear
  // ----------------------------------------------------------------
  wire clr_ae = stat_wr & writedata[`FCC_BIT_AE];
  wire clr_pv = stat_wr & writedata[`FCC_BIT_PV];
  wire access_error_flag_nxt = ae_set | (access_error_flag_r & ~clr_ae);
  wire protection_violation_flag_nxt = pv_set | (protection_violation_flag_r & ~clr_pv);

  // ----------------------------------------------------------------
  // protection register
  // ----------------------------------------------------------------
  always_comb begin
    prot_nxt = prot_r;
    if (prot_load) begin
      prot_nxt = prot_load_value;
    end else if (reg_wr & sel_prot & normal_mode) begin
      prot_nxt.open_all = prot_r.open_all & writedata[`FCC_BIT_OPEN];
      prot_nxt.high_dis = writedata[`FCC_BIT_HDIS];
      prot_nxt.low_dis = writedata[`FCC_BIT_LDIS];
      if (prot_r.high_dis) begin
        prot_nxt.high_size = writedata[`FCC_BIT_HS +: 2];
      end
      if (prot_r.low_dis) begin
        prot_nxt.low_protect_size_field = writedata[`FCC_BIT_LS +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire [7:0] stat_byte = {command_buffer_empty_flag, command_complete_flag, protection_violation_flag_r, access_error_flag_r, 4'h0};
  wire [15:0] arr_word = exec_busy ? INVALID_DATA : array_rdata;
  wire [31:0] prot_word = {24'h000000, prot_r.open_all, 1'b0, prot_r.high_dis,
                           prot_r.high_size, prot_r.low_dis, prot_r.low_protect_size_field};
  wire [31:0] rd_mux = hit_arr ? {arr_word, arr_word} :
                       sel_div ? {24'h000000, clkdiv_r} :
                       sel_prot ? prot_word :
                       sel_stat ? {24'h000000, stat_byte} :
                       sel_cmd ? {24'h000000, buf_r.code} : 32'h00000000;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      wait_r <= ~(req & wait_r);
      if (read & wait_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequence and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= flash_cmd_check_pkg::SEQ_IDLE;
      access_error_flag_r <= 1'b0;
      protection_violation_flag_r <= 1'b0;
      div_done_r <= 1'b0;
      clkdiv_r <= `FCC_RST_CLKDIV;
      prot_r <= flash_cmd_check_pkg::prot_t'(7'(`FCC_RST_PROT));
    end else begin
      state_r <= state_nxt;
      access_error_flag_r <= access_error_flag_nxt;
      protection_violation_flag_r <= protection_violation_flag_nxt;
      prot_r <= prot_nxt;
      if (reg_wr & sel_div) begin
        clkdiv_r <= writedata[7:0];
        div_done_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // command buffer and hand-off
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      buf_r <= '0;
      cmd_r <= '0;
      cmd_valid_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      abort_r <= ae_stop;
      if (word_good) begin
        buf_r.addr <= arr_addr;
        buf_r.data <= lane_data;
      end
      if (cmd_good) begin
        buf_r.code <= wr_code;
      end
      if (ae_stop) begin
        cmd_valid_r <= 1'b0;
      end else if (launch) begin
        cmd_valid_r <= 1'b1;
        cmd_r <= buf_r;
      end else if (handoff) begin
        cmd_valid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // stop pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stop_s1_r <= 1'b0;
      stop_s2_r <= 1'b0;
      stop_s3_r <= 1'b0;
    end else begin
      stop_s1_r <= stop_req;
      stop_s2_r <= stop_s1_r;
      stop_s3_r <= stop_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign readdata = rdata_r;
  assign waitrequest = wait_r;
  assign cmd_valid = cmd_valid_r;
  assign cmd_out = cmd_r;
  assign cmd_abort = abort_r;
  assign clkdiv = clkdiv_r;
  assign access_error_flag = access_error_flag_r;
  assign protection_violation_flag = protection_violation_flag_r;

endmodule : flash_command_error_checker

`default_nettype wire

/* File: flash_command_error_checker_test.sv */
// Purpose: self-checking bench of the flash command error checker
// Assumes: engine model on the launch side
// Notes: protection image loads a 2 Kbyte low range
`timescale 1ns/1ns
`default_nettype none

module flash_command_error_checker_test;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic read = 1'b0, write = 1'b0, src_nonsecure = 1'b0, src_debug = 1'b0;
  logic secure_en = 1'b0, prot_load = 1'b0, stop_req = 1'b0, stall = 1'b0;
  logic normal_mode = 1'b1;
  logic [15:0] address = 16'h0000;
  logic [15:0] array_rdata = 16'h5a5a;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'h0;
  flash_cmd_check_pkg::prot_t prot_load_value = 7'h79;
  wire logic [31:0] readdata;
  wire logic waitrequest, exec_busy, engine_ready, cmd_valid, cmd_abort;
  wire logic access_error_flag, protection_violation_flag;
  wire logic [7:0] clkdiv;
  wire flash_cmd_check_pkg::cmd_t cmd_out;
  int err_total = 0;
  int checked = 0;
  logic [31:0] rv;
  always #10 clk_sys = ~clk_sys;
  flash_command_error_checker flash_command_error_checker_i (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .src_nonsecure(src_nonsecure), .src_debug(src_debug),
    .secure_en(secure_en), .normal_mode(normal_mode), .array_rdata(array_rdata),
    .prot_load(prot_load), .prot_load_value(prot_load_value), .stop_req(stop_req),
    .exec_busy(exec_busy), .engine_ready(engine_ready), .cmd_valid(cmd_valid),
    .cmd_out(cmd_out), .cmd_abort(cmd_abort), .clkdiv(clkdiv),
    .access_error_flag(access_error_flag),
    .protection_violation_flag(protection_violation_flag));
  flash_engine_model flash_engine_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_abort(cmd_abort), .stall(stall),
    .engine_ready(engine_ready), .exec_busy(exec_busy));
  // ----
  // bus and check helpers
  // ----
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= 1'b1;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(negedge clk_sys);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    address <= a;
    read <= 1'b1;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    rv = readdata;
    read <= 1'b0;
    @(negedge clk_sys);
  endtask : rd
  task automatic word(input logic [15:0] a);
    wr(a, 32'h0000_1234, 4'h3);
  endtask : word
  task automatic cmd(input logic [7:0] c);
    wr(16'h010c, {24'h0, c}, 4'h1);
  endtask : cmd
  task automatic flags(input logic ae, input logic pv);
    chk("flags", {30'h0, ae, pv}, {30'h0, access_error_flag, protection_violation_flag});
    wr(16'h0108, 32'h0000_0030, 4'h1);
    chk("flags cleared", 32'h0, {30'h0, access_error_flag, protection_violation_flag});
  endtask : flags
  task automatic wait_low(input int n);
    for (int i = 0; i < n && (exec_busy !== 1'b0 || cmd_valid !== 1'b0); i++) @(negedge clk_sys);
  endtask : wait_low
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    rd(16'h0108);
    chk("status", 32'h0000_00c0, rv);
    rd(16'h0104);
    chk("prot", 32'h0000_00bf, rv);
    word(16'h8000);
    chk("ae", 32'h1, {31'h0, access_error_flag});
    wr(16'h0108, 32'h0000_0000, 4'h1);
    flags(1'b1, 1'b0);
    wr(16'h0100, 32'h0000_0013, 4'h1);
    chk("clkdiv", 32'h13, {24'h0, clkdiv});
  endtask : t_reset
  task automatic t_launch;
    word(16'h8000);
    rd(16'h0108);
    rd(16'h0200);
    chk("unmapped", 32'h0, rv);
    cmd(8'h02);
    wr(16'h0108, 32'h0000_0080, 4'h1);
    for (int i = 0; i < 4 && cmd_valid !== 1'b1; i++) @(negedge clk_sys);
    chk("code", 32'h02, {24'h0, cmd_out.code});
    chk("addr data", 32'h8000_1234, {cmd_out.addr, cmd_out.data});
    for (int i = 0; i < 4 && exec_busy !== 1'b1; i++) @(negedge clk_sys);
    rd(16'h8000);
    chk("busy read", 32'hffff_ffff, rv);
    flags(1'b0, 1'b0);
    wait_low(40);
  endtask : t_launch
  task automatic t_order;
    wr(16'h8000, 32'h0, 4'h1);
    flags(1'b1, 1'b0);
    wr(16'h8000, 32'h0, 4'h6);
    flags(1'b1, 1'b0);
    word(16'h8000);
    word(16'h8004);
    flags(1'b1, 1'b0);
    word(16'h8000);
    wr(16'h0108, 32'h0000_0080, 4'h1);
    flags(1'b1, 1'b0);
    word(16'h8000);
    cmd(8'h02);
    cmd(8'h02);
    flags(1'b1, 1'b0);
    word(16'h8000);
    cmd(8'h7f);
    flags(1'b1, 1'b0);
    word(16'h8000);
    cmd(8'h03);
    wr(16'h0100, 32'h0000_0013, 4'h1);
    flags(1'b1, 1'b0);
    word(16'h8000);
    cmd(8'h01);
    wr(16'h0108, 32'h0, 4'h1);
    flags(1'b1, 1'b0);
  endtask : t_order
  task automatic t_lock;
    wr(16'h8000, 32'h0, 4'h1);
    word(16'h8000);
    cmd(8'h02);
    wr(16'h0108, 32'h0000_0080, 4'h1);
    repeat (3) @(negedge clk_sys);
    chk("locked", 32'h0, {31'h0, cmd_valid});
    wr(16'h0108, 32'h0, 4'h1);
    flags(1'b1, 1'b0);
  endtask : t_lock
  task automatic t_secure;
    @(posedge clk_sys);
    secure_en <= 1'b1;
    src_nonsecure <= 1'b1;
    word(16'h8000);
    cmd(8'h02);
    flags(1'b1, 1'b0);
    @(posedge clk_sys);
    src_nonsecure <= 1'b0;
    src_debug <= 1'b1;
    word(16'h8000);
    cmd(8'h03);
    flags(1'b1, 1'b0);
    @(posedge clk_sys);
    secure_en <= 1'b0;
    src_debug <= 1'b0;
  endtask : t_secure
  task automatic t_prot;
    logic [15:0] a [4] = '{16'h47fc, 16'h4800, 16'h4000, 16'h8000};
    logic [7:0] c [4] = '{8'h02, 8'h02, 8'h03, 8'h04};
    logic e [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      word(a[i]);
      cmd(c[i]);
      chk("pv", {31'h0, e[i]}, {31'h0, protection_violation_flag});
      wr(16'h0108, 32'h0, 4'h1);
      wr(16'h0108, 32'h0000_0030, 4'h1);
    end
    wr(16'h0104, 32'h0000_00fd, 4'h1);
    rd(16'h0104);
    chk("prot written", 32'h0000_00bd, rv);
  endtask : t_prot
  task automatic t_pend_stop;
    @(posedge clk_sys);
    stall <= 1'b1;
    word(16'h8000);
    cmd(8'h02);
    wr(16'h0108, 32'h0000_0080, 4'h1);
    word(16'h8004);
    chk("ae", 32'h1, {31'h0, access_error_flag});
    @(posedge clk_sys);
    stall <= 1'b0;
    wait_low(40);
    flags(1'b1, 1'b0);
    word(16'h8000);
    cmd(8'h03);
    wr(16'h0108, 32'h0000_0080, 4'h1);
    for (int i = 0; i < 6 && exec_busy !== 1'b1; i++) @(negedge clk_sys);
    @(posedge clk_sys);
    stop_req <= 1'b1;
    for (int i = 0; i < 8 && cmd_abort !== 1'b1; i++) @(negedge clk_sys);
    chk("abort", 32'h1, {31'h0, cmd_abort});
    @(posedge clk_sys);
    stop_req <= 1'b0;
    @(negedge clk_sys);
    flags(1'b1, 1'b0);
  endtask : t_pend_stop
  task automatic stop_test;
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    @(posedge clk_sys);
    prot_load <= 1'b1;
    @(posedge clk_sys);
    prot_load <= 1'b0;
    t_launch();
    t_order();
    t_lock();
    t_secure();
    t_prot();
    t_pend_stop();
    stop_test();
  end
  initial begin
    repeat (6000) @(posedge clk_sys);
    err_total++;
    stop_test();
  end
endmodule : flash_command_error_checker_test

`default_nettype wire

/* File: flash_engine_model.sv */
// Purpose: flash engine that takes launched commands
// Assumes: busy for a fixed span per command
// Notes: stall holds off acceptance
`timescale 1ns/1ns
`default_nettype none

module flash_engine_model #(
  parameter int BUSY_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic cmd_abort,
  input wire logic stall,
  output logic engine_ready,
  output logic exec_busy
);
  logic [7:0] cnt_r;
  assign exec_busy = cnt_r != 8'h00;
  assign engine_ready = !stall && !exec_busy;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) cnt_r <= 8'h00;
    else if (cmd_abort) cnt_r <= 8'h00;
    else if (cmd_valid && engine_ready) cnt_r <= BUSY_CYCLES[7:0];
    else if (exec_busy) cnt_r <= cnt_r - 8'h01;
  end
endmodule : flash_engine_model

`default_nettype wire
